// *** rtl/taimc_pkg.sv ***
// Shared constants and types of the touch converter control block.
// Assumes a classic Wishbone slave with byte addresses and 32-bit data.
package taimc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Code width and sequencing counts
  localparam int CODE_W = 12;
  localparam logic [3:0] ACQ_CYCLES = 4'h3;
  localparam logic [3:0] MSB_IDX = 4'hb;
  localparam logic [11:0] DAC_FIRST = 12'h800;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_RESULT = 4'h8;
  localparam logic [3:0] ADR_CFG = 4'hc;

  // Command register fields
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_MODE_BIT = 3;
  localparam int CTRL_PWR_BIT = 4;
  localparam int CTRL_START_BIT = 7;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_REF_BIT = 2;
  localparam int STAT_VALID_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Analog routing selections
  typedef enum logic [2:0] {
    POS_NONE, POS_XP, POS_YP, POS_YN, POS_VBAT, POS_AUX, POS_TEMP
  } taimc_pos_in_type;

  typedef enum logic [1:0] {NEG_GND, NEG_YN, NEG_XN} taimc_neg_in_type;
  typedef enum logic [1:0] {REFP_VREF, REFP_YP, REFP_XP} taimc_ref_pos_type;
  typedef enum logic [1:0] {REFN_GND, REFN_YN, REFN_XN} taimc_ref_neg_type;

  // Full front-end setting for one measurement
  typedef struct packed {
    taimc_pos_in_type posIn;
    taimc_neg_in_type negIn;
    taimc_ref_pos_type refPos;
    taimc_ref_neg_type refNeg;
    logic xpDrv;
    logic xnDrv;
    logic ypDrv;
    logic ynDrv;
    logic diodeOn;
    logic diodeHigh;
    logic batDivOn;
    logic measValid;
  } taimc_cfg_type;

  localparam taimc_cfg_type CFG_OFF = '{
    posIn: POS_NONE, negIn: NEG_GND, refPos: REFP_VREF, refNeg: REFN_GND,
    xpDrv: 1'b0, xnDrv: 1'b0, ypDrv: 1'b0, ynDrv: 1'b0,
    diodeOn: 1'b0, diodeHigh: 1'b0, batDivOn: 1'b0, measValid: 1'b0
  };

  typedef enum logic [2:0] {
    PH_IDLE, PH_SETUP, PH_ACQUIRE, PH_HOLD, PH_CONVERT
  } taimc_phase_type;

  // Whole state of the control block
  typedef struct packed {
    taimc_phase_type phase;
    logic [3:0] cnt;
    logic [3:0] bitIdx;
    logic [2:0] cmdAddr;
    logic cmdRefMode;
    logic cmdRefPwr;
    taimc_cfg_type cfg;
    logic holdOn;
    logic [11:0] dac;
    logic [11:0] result;
    logic done;
    logic ack;
    logic [31:0] rdata;
  } taimc_state_type;

endpackage

// *** rtl/taimc_mux_decode.sv ***
// Channel decoder: address and reference mode to front-end routing.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module taimc_mux_decode (
  // Command fields
  input wire logic [2:0] chanAddr,
  input wire logic refModeSel,
  // Decoded routing
  output taimc_pkg::taimc_cfg_type cfg
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode table, single-ended then differential
  always_comb begin
    cfg = taimc_pkg::CFG_OFF;
    if (refModeSel) begin
      // Single-ended: reference from the pin, minus input on ground
      cfg.measValid = 1'b1;
      unique case (chanAddr)
        3'h0: begin
          cfg.posIn = taimc_pkg::POS_TEMP;
          cfg.diodeOn = 1'b1;
        end
        3'h1: begin
          cfg.posIn = taimc_pkg::POS_XP;
          cfg.ypDrv = 1'b1;
          cfg.ynDrv = 1'b1;
        end
        3'h2: begin
          cfg.posIn = taimc_pkg::POS_VBAT;
          cfg.batDivOn = 1'b1;
        end
        3'h3: begin
          cfg.posIn = taimc_pkg::POS_XP;
          cfg.xnDrv = 1'b1;
          cfg.ypDrv = 1'b1;
        end
        3'h4: begin
          cfg.posIn = taimc_pkg::POS_YN;
          cfg.xnDrv = 1'b1;
          cfg.ypDrv = 1'b1;
        end
        3'h5: begin
          cfg.posIn = taimc_pkg::POS_YP;
          cfg.xpDrv = 1'b1;
          cfg.xnDrv = 1'b1;
        end
        3'h6: begin
          cfg.posIn = taimc_pkg::POS_AUX;
        end
        3'h7: begin
          cfg.posIn = taimc_pkg::POS_TEMP;
          cfg.diodeOn = 1'b1;
          cfg.diodeHigh = 1'b1;
        end
      endcase
    end else begin
      // Differential: references tied to the driven plate nodes
      unique case (chanAddr)
        3'h1: begin
          cfg.measValid = 1'b1;
          cfg.posIn = taimc_pkg::POS_XP;
          cfg.negIn = taimc_pkg::NEG_YN;
          cfg.refPos = taimc_pkg::REFP_YP;
          cfg.refNeg = taimc_pkg::REFN_YN;
          cfg.ypDrv = 1'b1;
          cfg.ynDrv = 1'b1;
        end
        3'h3, 3'h4: begin
          cfg.measValid = 1'b1;
          cfg.posIn = (chanAddr == 3'h3) ? taimc_pkg::POS_XP : taimc_pkg::POS_YN;
          cfg.negIn = taimc_pkg::NEG_XN;
          cfg.refPos = taimc_pkg::REFP_YP;
          cfg.refNeg = taimc_pkg::REFN_XN;
          cfg.ypDrv = 1'b1;
          cfg.xnDrv = 1'b1;
        end
        3'h5: begin
          cfg.measValid = 1'b1;
          cfg.posIn = taimc_pkg::POS_YP;
          cfg.negIn = taimc_pkg::NEG_XN;
          cfg.refPos = taimc_pkg::REFP_XP;
          cfg.refNeg = taimc_pkg::REFN_XN;
          cfg.xpDrv = 1'b1;
          cfg.xnDrv = 1'b1;
        end
        // Non-panel codes have no ratiometric meaning: all off
        3'h0, 3'h2, 3'h6, 3'h7: begin
          cfg.measValid = 1'b0;
        end
      endcase
    end
  end

endmodule // taimc_mux_decode

// *** rtl/taimc_control.sv ***
// Control logic of a touch-screen SAR converter behind a Wishbone slave.
// Assumes a classic Wishbone master and an analog front end that follows
// the routing outputs and answers the SAR trial level on cmpHigh.
`timescale 1ns/100ps
module taimc_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // Analog front end
  output taimc_pkg::taimc_cfg_type muxCfg,
  output logic intRefOn,
  output logic sampleHold,
  output logic [11:0] dacCode,
  input wire logic cmpHigh
);

  taimc_pkg::taimc_state_type st;
  taimc_pkg::taimc_state_type nxt;
  taimc_pkg::taimc_cfg_type decCfg;
  logic busReq;
  logic busyNow;
  logic ctrlWr;
  logic doneClr;
  logic startReq;

  ////////////////////////////////////////////////////////////////////////////
  // Decoder on the stored command, stable once a command is taken
  taimc_mux_decode u_decode (
    .chanAddr(st.cmdAddr),
    .refModeSel(st.cmdRefMode),
    .cfg(decCfg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus qualifiers; ack is one cycle so a held request is taken once
  assign busReq = wbCyc && wbStb && !st.ack;
  assign busyNow = (st.phase != taimc_pkg::PH_IDLE);
  // Commands while busy are dropped so routing never changes mid-sample
  assign ctrlWr = busReq && wbWe && (wbAdr == taimc_pkg::ADR_CTRL) && wbSel[0] && !busyNow;
  assign doneClr = busReq && wbWe && (wbAdr == taimc_pkg::ADR_STATUS) && wbSel[0]
    && wbDatW[taimc_pkg::STAT_DONE_BIT];
  assign startReq = ctrlWr && wbDatW[taimc_pkg::CTRL_START_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus slave, command store and conversion sequence
  always_comb begin
    logic [11:0] trial;
    trial = st.dac;
    nxt = st;
    // Single-cycle ack; it falls in the cycle after it was given
    nxt.ack = busReq;
    if (busReq && !wbWe) begin
      unique case (wbAdr)
        taimc_pkg::ADR_CTRL: begin
          nxt.rdata = {24'h000000, 1'b0, 2'h0, st.cmdRefPwr, st.cmdRefMode, st.cmdAddr};
        end
        taimc_pkg::ADR_STATUS: begin
          nxt.rdata = {28'h0000000, st.cfg.measValid, st.cmdRefPwr, st.done, busyNow};
        end
        taimc_pkg::ADR_RESULT: begin
          nxt.rdata = {20'h00000, st.result};
        end
        taimc_pkg::ADR_CFG: begin
          nxt.rdata = {{(32 - $bits(taimc_pkg::taimc_cfg_type)){1'b0}}, st.cfg};
        end
        default: begin
          nxt.rdata = 32'h00000000;
        end
      endcase
    end
    // Command fields taken from the serial-equivalent command word
    if (ctrlWr) begin
      nxt.cmdAddr = wbDatW[taimc_pkg::CTRL_ADDR_LSB +: 3];
      nxt.cmdRefMode = wbDatW[taimc_pkg::CTRL_MODE_BIT];
      nxt.cmdRefPwr = wbDatW[taimc_pkg::CTRL_PWR_BIT];
    end
    // Clear first so a completion in the same cycle wins
    if (doneClr) begin
      nxt.done = 1'b0;
    end
    unique case (st.phase)
      taimc_pkg::PH_IDLE: begin
        if (startReq) begin
          nxt.phase = taimc_pkg::PH_SETUP;
        end
      end
      taimc_pkg::PH_SETUP: begin
        // Apply decoded routing and driver settings
        nxt.cfg = decCfg;
        nxt.cnt = 4'h0;
        nxt.phase = taimc_pkg::PH_ACQUIRE;
      end
      taimc_pkg::PH_ACQUIRE: begin
        nxt.cnt = 4'(st.cnt + 4'h1);
        if (st.cnt == 4'(taimc_pkg::ACQ_CYCLES - 4'h1)) begin
          // Diode bias and battery divider only live during acquisition
          nxt.cfg.diodeOn = 1'b0;
          nxt.cfg.batDivOn = 1'b0;
          nxt.holdOn = 1'b1;
          nxt.phase = taimc_pkg::PH_HOLD;
        end
      end
      taimc_pkg::PH_HOLD: begin
        // Sample is frozen on the array; start the search at mid-scale
        nxt.dac = taimc_pkg::DAC_FIRST;
        nxt.bitIdx = taimc_pkg::MSB_IDX;
        nxt.phase = taimc_pkg::PH_CONVERT;
      end
      taimc_pkg::PH_CONVERT: begin
        // One bit per cycle, MSB first, straight binary
        if (!cmpHigh) begin
          trial[st.bitIdx] = 1'b0;
        end
        if (st.bitIdx == 4'h0) begin
          nxt.result = trial;
          nxt.done = 1'b1;
          nxt.holdOn = 1'b0;
          nxt.cfg = taimc_pkg::CFG_OFF;
          nxt.phase = taimc_pkg::PH_IDLE;
        end else begin
          trial[4'(st.bitIdx - 4'h1)] = 1'b1;
          nxt.bitIdx = 4'(st.bitIdx - 4'h1);
        end
        nxt.dac = trial;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reference power resets off, matching the required
  // first host command, so a missed command cannot leave it burning power
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register
  assign wbDatR = st.rdata;
  assign wbAck = st.ack;
  assign muxCfg = st.cfg;
  assign intRefOn = st.cmdRefPwr;
  assign sampleHold = st.holdOn;
  assign dacCode = st.dac;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic inAcq;
  assign inAcq = (st.phase == taimc_pkg::PH_ACQUIRE);

  // Command bits land in the store one cycle after the write
  cmd_store_a: assert property (
    ctrlWr |=> (st.cmdAddr == $past(wbDatW[2:0])) && (st.cmdRefMode == $past(wbDatW[3])))
    else $error("command fields not stored");

  // Reference enable output follows the power bit of each command taken while idle
  ref_power_a: assert property (
    ctrlWr |=> (intRefOn == $past(wbDatW[4])) ##1 $stable(intRefOn) || $past(ctrlWr))
    else $error("reference enable does not follow command");

  // Differential vertical: references on Y plate nodes
  diff_yref_a: assert property (
    (inAcq && !st.cmdRefMode && st.cmdAddr == 3'h1) |->
      (muxCfg.refPos == taimc_pkg::REFP_YP) && (muxCfg.refNeg == taimc_pkg::REFN_YN)
      && muxCfg.ypDrv && muxCfg.ynDrv)
    else $error("differential vertical reference wrong");

  // Single-ended vertical: X+ on plus input, only Y drivers
  se_ypos_a: assert property (
    (inAcq && st.cmdRefMode && st.cmdAddr == 3'h1) |->
      (muxCfg.posIn == taimc_pkg::POS_XP) && muxCfg.ypDrv && muxCfg.ynDrv
      && !muxCfg.xpDrv && !muxCfg.xnDrv)
    else $error("vertical routing wrong");

  // Conversion takes twelve bit cycles then reports done; the bit index
  // pins the length, so no long repetition has to be unrolled
  sequence convEntry;
    $rose(st.phase == taimc_pkg::PH_CONVERT);
  endsequence
  sequence convLastBit;
    (st.phase == taimc_pkg::PH_CONVERT) && (st.bitIdx == 4'h0);
  endsequence
  sar_length_a: assert property (
    convEntry |-> ##11 convLastBit
      ##1 (st.phase == taimc_pkg::PH_IDLE && st.done))
    else $error("conversion length not twelve bits");

  // Differential panel measurements never use the reference pin
  diff_noref_a: assert property (
    (inAcq && !st.cmdRefMode && muxCfg.measValid) |->
      (muxCfg.refPos != taimc_pkg::REFP_VREF))
    else $error("differential mode uses reference pin");

  // Hold is entered from acquisition and is still on when conversion starts at mid-scale
  sequence holdEntry;
    inAcq ##1 (st.phase == taimc_pkg::PH_HOLD);
  endsequence
  hold_then_conv_a: assert property (
    holdEntry |-> sampleHold ##1 (sampleHold && st.phase == taimc_pkg::PH_CONVERT
      && dacCode == 12'h800))
    else $error("hold not followed by conversion");

  // Single-ended temperature codes: diode on, drivers off
  se_temp_a: assert property (
    (inAcq && st.cmdRefMode && (st.cmdAddr == 3'h0 || st.cmdAddr == 3'h7)) |->
      (muxCfg.posIn == taimc_pkg::POS_TEMP) && muxCfg.diodeOn
      && (muxCfg.diodeHigh == (st.cmdAddr == 3'h7))
      && !(muxCfg.xpDrv || muxCfg.xnDrv || muxCfg.ypDrv || muxCfg.ynDrv))
    else $error("temperature routing wrong");

  // Differential pressure codes: Y+ and X- references and drivers
  diff_zref_a: assert property (
    (inAcq && !st.cmdRefMode && (st.cmdAddr == 3'h3 || st.cmdAddr == 3'h4)) |->
      (muxCfg.refPos == taimc_pkg::REFP_YP) && (muxCfg.refNeg == taimc_pkg::REFN_XN)
      && muxCfg.ypDrv && muxCfg.xnDrv && !muxCfg.xpDrv && !muxCfg.ynDrv)
    else $error("pressure reference wrong");

  // Bus answers in one cycle and drops ack the next
  bus_ack_a: assert property (
    busReq |=> wbAck ##1 !wbAck)
    else $error("ack timing wrong");

endmodule // taimc_control

// *** test/taimc_front_model.sv ***
// Behavioural analog front end: plate, battery, auxiliary and diode sources.
// Assumes the routing outputs of the control block and its SAR trial code.
`timescale 1ns/100ps
module taimc_front_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Routing and SAR side
  input wire taimc_pkg::taimc_cfg_type muxCfg,
  input wire logic sampleHold,
  input wire logic [11:0] dacCode,
  output logic cmpHigh
);
  logic [11:0] heldLvl_ff;
  logic junk_ff;

  // Each routed input carries its own fixed level
  function automatic logic [11:0] src_lvl(input taimc_pkg::taimc_pos_in_type p);
    return {p, 9'h0a5};
  endfunction

  // Track the routed input, freeze it while held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      heldLvl_ff <= 12'h000;
      junk_ff <= 1'b0;
    end else begin
      junk_ff <= ~junk_ff;
      if (!sampleHold) heldLvl_ff <= src_lvl(muxCfg.posIn);
    end
  end

  // Outside hold the answer toggles, so a stray sample cannot pass
  assign cmpHigh = sampleHold ? (heldLvl_ff >= dacCode) : junk_ff;
endmodule // taimc_front_model

// *** test/testbench.sv ***
// Self-checking bench of the touch converter control block.
// Assumes the front-end model answers SAR trials from fixed levels.
`timescale 1ns/100ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module testbench;
  logic clk, rst_n, wbCyc, wbStb, wbWe, wbAck, intRefOn, sampleHold, cmpHigh;
  logic [3:0] wbAdr, wbSel;
  logic [31:0] wbDatW, wbDatR;
  logic [11:0] dacCode;
  taimc_pkg::taimc_cfg_type muxCfg;
  int error_cnt;
  int compares;

  taimc_control taimc_control_i (.clk(clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR),
    .wbAck(wbAck), .muxCfg(muxCfg), .intRefOn(intRefOn), .sampleHold(sampleHold),
    .dacCode(dacCode), .cmpHigh(cmpHigh));
  taimc_front_model taimc_front_model_i (.clk(clk), .rst_n(rst_n), .muxCfg(muxCfg),
    .sampleHold(sampleHold), .dacCode(dacCode), .cmpHigh(cmpHigh));

  ////////////////////////////////////////
  // Compare and verdict
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t got %0h exp %0h", $time, g, e);
    end
  endtask

  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Classic cycle: hold the request until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                         input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatW <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatR;
    if (n >= 50) error_cnt++;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wb_wr(input logic [3:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    wb_xfer(1'b1, adr, 4'hf, dat, rd);
  endtask

  task automatic wb_rd(input logic [3:0] adr, output logic [31:0] rd);
    wb_xfer(1'b0, adr, 4'hf, 32'h0, rd);
  endtask

  // Poll until busy drops; bounded so a stuck busy ends the wait
  task automatic wait_idle(output logic [31:0] st);
    int n;
    n = 0;
    do begin
      wb_rd(taimc_pkg::ADR_STATUS, st);
      n++;
    end while (st[0] !== 1'b0 && n < 20);
  endtask

  // Expected front-end setting for a command
  function automatic taimc_pkg::taimc_cfg_type exp_cfg(input logic [2:0] a, input logic m);
    taimc_pkg::taimc_cfg_type c;
    c = taimc_pkg::CFG_OFF;
    c.measValid = 1'b1;
    case (a)
      3'h0, 3'h7: begin
        c.posIn = taimc_pkg::POS_TEMP;
        c.diodeOn = 1'b1;
        c.diodeHigh = a[0];
      end
      3'h2: begin
        c.posIn = taimc_pkg::POS_VBAT;
        c.batDivOn = 1'b1;
      end
      3'h6: c.posIn = taimc_pkg::POS_AUX;
      3'h1: begin
        c.posIn = taimc_pkg::POS_XP;
        {c.ypDrv, c.ynDrv} = 2'b11;
      end
      3'h3, 3'h4: begin
        c.posIn = a[0] ? taimc_pkg::POS_XP : taimc_pkg::POS_YN;
        {c.xnDrv, c.ypDrv} = 2'b11;
      end
      default: begin
        c.posIn = taimc_pkg::POS_YP;
        {c.xpDrv, c.xnDrv} = 2'b11;
      end
    endcase
    if (!m) begin
      c.negIn = (a == 3'h1) ? taimc_pkg::NEG_YN : taimc_pkg::NEG_XN;
      c.refPos = (a == 3'h5) ? taimc_pkg::REFP_XP : taimc_pkg::REFP_YP;
      c.refNeg = (a == 3'h1) ? taimc_pkg::REFN_YN : taimc_pkg::REFN_XN;
      if (a == 3'h0 || a == 3'h2 || a == 3'h6 || a == 3'h7) c = taimc_pkg::CFG_OFF;
    end
    return c;
  endfunction

  ////////////////////////////////////////
  // Scenarios
  task automatic test_reset();
    logic [31:0] rd;
    logic [3:0] adrs [4] = '{4'h4, 4'h8, 4'hc, 4'h2};
    `CHK({intRefOn, sampleHold, muxCfg}, 19'h0);
    for (int i = 0; i < 4; i++) begin
      wb_rd(adrs[i], rd);
      `CHK(rd, 32'h0);
    end
    wb_wr(taimc_pkg::ADR_CTRL, 32'h0);
    $display("test reset finished");
  endtask

  task automatic test_refpwr();
    logic [31:0] rd;
    wb_wr(taimc_pkg::ADR_CTRL, 32'h10);
    #1;
    `CHK(intRefOn, 1'b1);
    wb_rd(taimc_pkg::ADR_STATUS, rd);
    `CHK(rd[2], 1'b1);
    wb_xfer(1'b1, taimc_pkg::ADR_CTRL, 4'he, 32'h0, rd);
    #1;
    `CHK(intRefOn, 1'b1);
    wb_wr(taimc_pkg::ADR_CTRL, 32'h0);
    #1;
    `CHK(intRefOn, 1'b0);
    $display("test refpwr finished");
  endtask

  // One conversion: routing at E+2, hold at E+5, code after idle
  task automatic run_meas(input logic [2:0] a, input logic m);
    taimc_pkg::taimc_cfg_type e;
    logic [31:0] rd;
    e = exp_cfg(a, m);
    wb_wr(taimc_pkg::ADR_CTRL, {24'h0, 1'b1, 3'h0, m, a});
    @(posedge clk);
    #1;
    `CHK(muxCfg, e);
    repeat (3) @(posedge clk);
    #1;
    `CHK({sampleHold, muxCfg.diodeOn, muxCfg.batDivOn}, 3'h4);
    wait_idle(rd);
    `CHK(rd[1:0], 2'b10);
    `CHK(muxCfg, taimc_pkg::CFG_OFF);
    wb_rd(taimc_pkg::ADR_RESULT, rd);
    if (e.measValid) `CHK(rd, {20'h0, e.posIn, 9'h0a5});
    wb_wr(taimc_pkg::ADR_STATUS, 32'h2);
  endtask

  task automatic test_decode();
    for (int m = 0; m < 2; m++) begin
      for (int a = 0; a < 8; a++) run_meas(3'(a), 1'(m));
    end
    $display("test decode finished");
  endtask

  // A command while busy is dropped whole, reference bit included
  task automatic test_busy();
    logic [31:0] rd;
    wb_wr(taimc_pkg::ADR_CTRL, 32'h85);
    wb_wr(taimc_pkg::ADR_CTRL, 32'h99);
    #1;
    `CHK(intRefOn, 1'b0);
    `CHK(muxCfg, exp_cfg(3'h5, 1'b0));
    wait_idle(rd);
    `CHK(rd[1:0], 2'b10);
    wb_rd(taimc_pkg::ADR_CTRL, rd);
    `CHK(rd, 32'h5);
    wb_wr(taimc_pkg::ADR_STATUS, 32'h2);
    wb_rd(taimc_pkg::ADR_STATUS, rd);
    `CHK(rd[1], 1'b0);
    $display("test busy finished");
  endtask

  ////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Main sequence, reset held 16 cycles
  initial begin
    rst_n = 1'b0;
    {wbCyc, wbStb, wbWe} = 3'h0;
    wbAdr = 4'h0;
    wbSel = 4'h0;
    wbDatW = 32'h0;
    error_cnt = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_refpwr();
    test_decode();
    test_busy();
    complete_run();
  end

  // Watchdog: the whole run needs about five hundred cycles
  initial begin
    #400000;
    error_cnt++;
    complete_run();
  end
endmodule // testbench
